// [common/phase_gen_map.svh]
// register map, field positions and timing constants of the phase generator
`ifndef PHASE_GEN_MAP_SVH
`define PHASE_GEN_MAP_SVH

`define REG_CTRL 8'h00
`define REG_CYCLE 8'h04
`define REG_STATUS 8'h08
`define REG_PHASE_BASE 8'h40
`define REG_PHASE_LAST 8'hC4

`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_CLEAR 2
`define CTRL_SEVEN 3
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 5

`define STAT_SLOW 0
`define STAT_HALT 1
`define STAT_RUN 2
`define STAT_SCAN 3
`define STAT_ERR_LO 4
`define STAT_ERR_HI 7

`define NUM_CH 17
`define NUM_PHASES 14
`define SEVEN_PHASES 4
`define FIRST_CMP_CH 14
`define TIME_W 21

`define MIN_CLK_NS 21'd48
`define FAST_MAX_NS 21'd16376
`define CYCLE_MAX_NS 21'd1048000
`define START_MARGIN_NS 21'd17
`define WIDTH_MARGIN_NS 21'd16
`define FAST_MIN_WIDTH_NS 21'd8
`define FAST_CYCLE_RES_NS 21'd8
`define SLOW_STEP_NS 512
`define SLOW_STEP_SHIFT 9
`define SLOW_HALF_NS 22'd256
`define CLK_PERIOD_NS 25
`define SLOW_DIV_DEFAULT (`SLOW_STEP_NS / 1)

`endif

// [common/phase_gen_pkg.sv]
// types of the phase generator
package phase_gen_pkg;
`include "phase_gen_map.svh"

  typedef enum logic [1:0] {
    GEN_IDLE,
    GEN_SCAN,
    GEN_RUN,
    GEN_HALT
  } gen_state_e;

  typedef enum logic [3:0] {
    ERR_NONE,
    ERR_CYCLE,
    ERR_CLOCK,
    ERR_MIX,
    ERR_WIDTH,
    ERR_MARGIN,
    ERR_MODE
  } gen_err_e;

  typedef logic [`TIME_W-1:0] time_t;

  typedef struct packed {
    gen_state_e st;
    gen_err_e err;
    logic [4:0] idx;
    logic slow;
    logic seven;
    logic [1:0] mode;
    time_t cycle_ns;
    time_t cyc_units;
    time_t cyc_cnt;
    logic [15:0] tick_cnt;
    logic marker;
    logic [`NUM_CH-1:0] busy;
    logic [`NUM_CH-1:0] act;
    logic [`NUM_CH-1:0] pulses;
    logic [`NUM_CH-1:0][`TIME_W-1:0] dly;
    logic [`NUM_CH-1:0][`TIME_W-1:0] wcnt;
    logic [`NUM_CH-1:0][`TIME_W-1:0] cs;
    logic [`NUM_CH-1:0][`TIME_W-1:0] cw;
    logic ack;
    logic [31:0] rdata;
    logic halted;
    logic active;
  } gen_s;
endpackage

// [rtl/phase_gen.sv]
// programmable phase pulse generator with a classic wishbone register port
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "phase_gen_map.svh"
module phase_gen
  import phase_gen_pkg::*;
#(
  parameter int unsigned SLOW_DIV = `SLOW_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [`NUM_PHASES-1:0] phase_pulse_channel,
  output logic hicompare_window,
  output logic locompare_window,
  output logic data_strobe,
  output logic period_start_marker,
  output logic slow_range,
  output logic error_halt,
  output logic running
);

  if (SLOW_DIV < 2 || SLOW_DIV > 65536) begin : g_bad_div
    $error("SLOW_DIV must lie in 2..65536");
  end

  gen_s q;
  gen_s d;
  time_t pstart [0:`NUM_CH-1];
  time_t pwidth [0:`NUM_CH-1];

  function automatic time_t round_slow(input time_t ns);
    logic [`TIME_W:0] sum;
    sum = {1'b0, ns} + `SLOW_HALF_NS;
    return time_t'(sum >> `SLOW_STEP_SHIFT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic chan_en(input int unsigned i, input logic seven);
    return !seven || i < `SEVEN_PHASES || i >= `FIRST_CMP_CH;
  endfunction

  logic bus_req;
  logic bus_wr;
  logic phase_hit;
  logic [4:0] phase_idx;
  logic start_cmd;
  logic tick;
  time_t s_ns;
  time_t w_ns;
  time_t s_rnd;
  time_t w_rnd;

  assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign bus_wr = bus_req & wb_we_i;
  assign phase_hit = wb_adr_i >= `REG_PHASE_BASE && wb_adr_i <= `REG_PHASE_LAST
                     && wb_adr_i[1:0] == 2'b00;
  assign phase_idx = 5'((wb_adr_i - `REG_PHASE_BASE) >> 3);
  assign start_cmd = bus_wr && wb_adr_i == `REG_CTRL && wb_sel_i[0]
                     && wb_dat_i[`CTRL_START] && (q.st == GEN_IDLE || q.st == GEN_RUN);
  assign tick = !q.slow || q.tick_cnt == 16'h0000;
  assign s_ns = pstart[q.idx];
  assign w_ns = pwidth[q.idx];
  assign s_rnd = round_slow(s_ns);
  assign w_rnd = round_slow(w_ns);

  // phase settings may change at any time; they only act at the next start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `NUM_CH; i++) begin
        pstart[i] <= '0;
        pwidth[i] <= '0;
      end
    end else if (bus_wr && phase_hit) begin
      if (wb_adr_i[2]) begin
        pwidth[phase_idx] <= time_t'(merge(32'(pwidth[phase_idx]), wb_dat_i, wb_sel_i));
      end else begin
        pstart[phase_idx] <= time_t'(merge(32'(pstart[phase_idx]), wb_dat_i, wb_sel_i));
      end
    end
  end

  always_comb begin
    time_t nxt_cnt;
    logic mk;
    logic [1:0] mode_in;
    logic fast_res_cut;
    nxt_cnt = '0;
    mk = 1'b0;
    mode_in = wb_dat_i[`CTRL_MODE_HI:`CTRL_MODE_LO];
    fast_res_cut = 1'b0;
    d = q;
    d.ack = bus_req;
    d.marker = 1'b0;
    d.pulses = '0;

    // register reads; unmapped addresses answer zero
    if (wb_adr_i == `REG_CTRL) begin
      d.rdata = 32'({q.mode, q.seven, 3'b000});
    end else if (wb_adr_i == `REG_CYCLE) begin
      d.rdata = 32'(q.cycle_ns);
    end else if (wb_adr_i == `REG_STATUS) begin
      d.rdata = 32'({q.err, q.st == GEN_SCAN, q.st == GEN_RUN, q.st == GEN_HALT, q.slow});
    end else if (phase_hit) begin
      d.rdata = wb_adr_i[2] ? 32'(pwidth[phase_idx]) : 32'(pstart[phase_idx]);
    end else begin
      d.rdata = 32'h0000_0000;
    end

    // cycle length is frozen while a check or a run uses it
    if (bus_wr && wb_adr_i == `REG_CYCLE && (q.st == GEN_IDLE || q.st == GEN_HALT)) begin
      d.cycle_ns = time_t'(merge(32'(q.cycle_ns), wb_dat_i, wb_sel_i));
    end
    if (bus_wr && wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
      d.seven = wb_dat_i[`CTRL_SEVEN];
      d.mode = mode_in;
    end

    case (q.st)
      GEN_IDLE, GEN_RUN: begin
        if (q.st == GEN_RUN) begin
          d.tick_cnt = (!q.slow || q.tick_cnt == 16'(SLOW_DIV - 1)) ? 16'h0000
                       : q.tick_cnt + 16'h0001;
          if (tick) begin
            nxt_cnt = (q.cyc_cnt >= q.cyc_units - 1'b1) ? '0 : q.cyc_cnt + 1'b1;
            d.cyc_cnt = nxt_cnt;
            mk = nxt_cnt == '0;
            d.marker = mk;
            for (int i = 0; i < `NUM_CH; i++) begin
              // a busy channel ignores markers, so long settings skip cycles
              if (!q.busy[i]) begin
                if (mk && q.cw[i] != '0) begin
                  d.busy[i] = 1'b1;
                  if (q.cs[i] == '0) begin
                    d.act[i] = 1'b1;
                    d.wcnt[i] = q.cw[i];
                  end else begin
                    d.dly[i] = q.cs[i];
                  end
                end
              end else if (!q.act[i]) begin
                if (q.dly[i] == 21'd1) begin
                  d.act[i] = 1'b1;
                  d.wcnt[i] = q.cw[i];
                end else begin
                  d.dly[i] = q.dly[i] - 1'b1;
                end
              end else if (q.wcnt[i] == 21'd1) begin
                d.act[i] = 1'b0;
                d.busy[i] = 1'b0;
              end else begin
                d.wcnt[i] = q.wcnt[i] - 1'b1;
              end
            end
          end
          for (int i = 0; i < `NUM_CH; i++) begin
            d.pulses[i] = d.act[i] && chan_en(i, q.seven);
          end
        end
        if (bus_wr && wb_adr_i == `REG_CTRL && wb_sel_i[0] && wb_dat_i[`CTRL_STOP]) begin
          d.st = GEN_IDLE;
          d.pulses = '0;
        end
        if (start_cmd) begin
          d.pulses = '0;
          d.idx = '0;
          d.err = ERR_NONE;
          d.slow = q.cycle_ns > `FAST_MAX_NS;
          fast_res_cut = 1'b1;
          if (mode_in == 2'b11) begin
            d.err = ERR_MODE;
          end else if (q.cycle_ns < `MIN_CLK_NS || q.cycle_ns > `CYCLE_MAX_NS) begin
            d.err = ERR_CYCLE;
          end else if (q.cycle_ns < (`MIN_CLK_NS << mode_in)) begin
            d.err = ERR_CLOCK;
          end
          if (d.slow) begin
            d.cyc_units = round_slow(q.cycle_ns);
          end else begin
            // cycle resolution is 8, 16 or 32 ns for mode 0, 1 or 2
            d.cyc_units = q.cycle_ns & ~((`FAST_CYCLE_RES_NS << mode_in) - 1'b1);
          end
          d.st = (d.err == ERR_NONE) ? GEN_SCAN : GEN_HALT;
        end
      end
      GEN_SCAN: begin
        // one phase per clock, so a bad phase stops the scan where it lies
        if (chan_en(32'(q.idx), q.seven) && (s_ns != '0 || w_ns != '0)) begin
          if (q.slow) begin
            d.cs[q.idx] = s_rnd;
            d.cw[q.idx] = w_rnd;
            if (w_rnd == '0) begin
              d.err = ERR_WIDTH;
            end
          end else if (s_ns > `FAST_MAX_NS || w_ns > `FAST_MAX_NS) begin
            d.err = ERR_MIX;
          end else begin
            d.cs[q.idx] = s_ns;
            d.cw[q.idx] = w_ns;
            if (w_ns < `FAST_MIN_WIDTH_NS) begin
              d.err = ERR_WIDTH;
            end else if ((s_ns < q.cyc_units && s_ns + `START_MARGIN_NS > q.cyc_units)
                         || (w_ns < q.cyc_units
                             && w_ns + `WIDTH_MARGIN_NS > q.cyc_units)) begin
              d.err = ERR_MARGIN;
            end
          end
        end else begin
          d.cs[q.idx] = '0;
          d.cw[q.idx] = '0;
        end
        if (d.err != ERR_NONE) begin
          d.st = GEN_HALT;
        end else if (q.idx == 5'(`NUM_CH - 1)) begin
          d.st = GEN_RUN;
          d.busy = '0;
          d.act = '0;
          d.tick_cnt = '0;
          d.cyc_cnt = q.cyc_units - 1'b1;
        end else begin
          d.idx = q.idx + 5'd1;
        end
      end
      GEN_HALT: begin
        // halt is sticky until software clears it
        if (bus_wr && wb_adr_i == `REG_CTRL && wb_sel_i[0] && wb_dat_i[`CTRL_CLEAR]) begin
          d.st = GEN_IDLE;
          d.err = ERR_NONE;
        end
      end
      default: begin
        d.st = GEN_IDLE;
      end
    endcase
    if (fast_res_cut && d.st == GEN_HALT) begin
      d.busy = '0;
      d.act = '0;
    end
    // status pins get their own flops, so no decode glitch reaches the error_halt and running pins
    d.halted = d.st == GEN_HALT;
    d.active = d.st == GEN_RUN;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign phase_pulse_channel = q.pulses[`NUM_PHASES-1:0];
  assign hicompare_window = q.pulses[14];
  assign locompare_window = q.pulses[15];
  assign data_strobe = q.pulses[16];
  assign period_start_marker = q.marker;
  assign slow_range = q.slow;
  assign error_halt = q.halted;
  assign running = q.active;

  // clocks between markers, for checking the cycle period
  logic [31:0] clk_gap;
  logic gap_seen;
  always_ff @(posedge clk) begin
    if (sys_rst || q.st != GEN_RUN) begin
      clk_gap <= 32'h0000_0001;
      gap_seen <= 1'b0;
    end else if (q.marker) begin
      clk_gap <= 32'h0000_0001;
      gap_seen <= 1'b1;
    end else begin
      clk_gap <= clk_gap + 32'h0000_0001;
    end
  end

  halt_quiet_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (q.st == GEN_HALT) |=> (phase_pulse_channel == '0 && !data_strobe
                            && !hicompare_window && !locompare_window))
    else $error("pulse output active while halted");

  seven_mask_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (q.seven && $past(q.seven)) |-> phase_pulse_channel[13:4] == '0)
    else $error("phase above four active in seven-phase mode");

  cycle_limit_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (start_cmd && wb_dat_i[5:4] != 2'b11
     && (q.cycle_ns < 21'd48 || q.cycle_ns > 21'd1048000))
    |=> (error_halt && q.err == ERR_CYCLE) [*2])
    else $error("out of range cycle did not halt");

  load_check_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (start_cmd && wb_dat_i[5:4] == 2'b10 && q.cycle_ns >= 21'd48
     && q.cycle_ns < 21'd192) |=> error_halt && q.err == ERR_CLOCK)
    else $error("short clock cycle did not halt");

  range_pick_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (q.st == GEN_SCAN) |-> slow_range == (q.cycle_ns >= 21'd16377))
    else $error("wrong range for cycle length");

  slow_round_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (q.st == GEN_SCAN && q.slow)
    |-> q.cyc_units == 21'(({1'b0, q.cycle_ns} + 22'd256) >> 9))
    else $error("slow cycle not rounded to 512 ns");

  fast_trunc_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (q.st == GEN_SCAN && !q.slow && q.mode == 2'b00)
    |-> q.cyc_units[2:0] == 3'b000 && q.cycle_ns - q.cyc_units < 21'd8)
    else $error("fast cycle not truncated to 8 ns");

  mixed_range_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (q.st == GEN_SCAN && !q.slow && chan_en(32'(q.idx), q.seven)
     && (s_ns > 21'd16376 || w_ns > 21'd16376)) |=> error_halt && q.err == ERR_MIX)
    else $error("slow phase under fast cycle not halted");

  slow_width_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (q.st == GEN_SCAN && q.slow && chan_en(32'(q.idx), q.seven)
     && w_ns != '0 && w_ns < 21'd256) |=> error_halt && q.err == ERR_WIDTH)
    else $error("zero slow width not halted");

  marker_period_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (q.marker && gap_seen && $stable(q.st))
    |-> clk_gap == (q.slow ? 32'(q.cyc_units) * SLOW_DIV : 32'(q.cyc_units)))
    else $error("marker spacing differs from cycle length");

endmodule

// [tb/pin_monitor.sv]
// pin-side model: measures offset, width and spacing of one phase output
`timescale 1ns/1ps
module pin_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic watch,
  input wire logic [4:0] ch,
  input wire logic marker,
  input wire logic [16:0] pulses,
  output logic meas_valid,
  output logic [31:0] meas
);
  logic [15:0] now = 16'h0;
  logic [15:0] mcnt = 16'h0;
  logic [15:0] last = 16'h0;
  logic [15:0] off = 16'h0;
  logic [15:0] gap = 16'h0;
  logic [15:0] wid = 16'h0;
  logic prev = 1'b1;
  logic have = 1'b0;
  logic gap_ok = 1'b0;
  logic p;
  assign p = pulses[ch];
  // offset is taken from the latest marker, so long starts show modulo the period
  always_ff @(posedge clk) begin
    now <= now + 16'h1;
    mcnt <= marker ? 16'h1 : mcnt + 16'h1;
    // held high while idle, so a pulse already up at arming is no rise
    prev <= p || !watch;
    meas_valid <= !p && prev && gap_ok && watch && !sys_rst;
    meas <= {gap[11:0], wid[9:0], off[9:0]};
    if (!watch || sys_rst) begin
      have <= 1'b0;
      gap_ok <= 1'b0;
    end
    // first pulse after arming only seeds the spacing, it is never reported
    if (p && !prev) begin
      off <= marker ? 16'h0 : mcnt;
      gap <= now - last;
      gap_ok <= have && watch;
      have <= watch;
      last <= now;
      wid <= 16'h1;
    end else if (p) begin
      wid <= wid + 16'h1;
    end
  end
endmodule

// [tb/tb_programmable_phase_generator.sv]
// self-checking bench for the phase generator
`timescale 1ns/1ps
`include "phase_gen_map.svh"
module tb_programmable_phase_generator;
  import phase_gen_pkg::*;
  localparam int SDIV = 4; // short slow tick keeps runs brief
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic watch = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [4:0] wsel = 5'h00;
  logic [31:0] dat_o, meas, v;
  logic ack, marker, slow, halt, run_o, mv, hi, lo, ds;
  logic [13:0] ph_o, acc;
  int num_errors = 0;
  int n_tests = 0;
  int k;
  logic [31:0] eq[$], mq[$], pq[$];
  string nq[$];
  int fk[4] = '{0, 13, 14, 16};
  int fs[4] = '{0, 5, 70, 33};
  int fw[4] = '{8, 12, 10, 20};
  logic [7:0] ms[4] = '{8'h04, 8'h04, 8'h22, 8'h62};
  int ec[10] = '{40, 1048001, 100, 100, 100, 100, 20000, 16376, 16377, 1048000};
  int es[10] = '{0, 0, 10, 85, 10, 10, 200, 0, 0, 0};
  int ew[10] = '{0, 0, 17000, 10, 4, 85, 53, 0, 0, 0};
  logic [7:0] est[10] = '{8'h12, 8'h12, 8'h32, 8'h52, 8'h42, 8'h52, 8'h42, 8'h04, 8'h05,
                          8'h05};

  always #12.5 clk = ~clk;

  phase_gen #(.SLOW_DIV(SDIV)) u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .phase_pulse_channel(ph_o), .hicompare_window(hi),
    .locompare_window(lo), .data_strobe(ds), .period_start_marker(marker),
    .slow_range(slow), .error_halt(halt), .running(run_o));
  pin_monitor u_pins (.clk(clk), .sys_rst(sys_rst), .watch(watch), .ch(wsel),
    .marker(marker), .pulses({ds, lo, hi, ph_o}), .meas_valid(mv), .meas(meas));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; a read leaves its expected word for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m = 32'hFFFF_FFFF, input string nm = "reg");
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    if (!w) begin
      eq.push_back(d & m);
      mq.push_back(m);
      nq.push_back(nm);
    end
    // no cycle count is assumed; a slave that never answers is left to the watchdog
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic ph(input int c, input int s, input int w);
    wr(`REG_PHASE_BASE + 8'(8 * c), 32'(s));
    wr(`REG_PHASE_BASE + 8'(8 * c + 4), 32'(w));
  endtask

  task automatic run(input int cy, input logic [7:0] c, input logic [7:0] st);
    wr(`REG_CYCLE, 32'(cy));
    wr(`REG_CTRL, {24'h0, c});
    repeat (40) @(posedge clk);
    bus(1'b0, `REG_STATUS, {24'h0, st}, st[1] ? 32'hFE : 32'hFF, "status");
    chk("halt pin", {31'h0, st[1]}, {31'h0, halt});
    chk("run pin", {31'h0, st[2]}, {31'h0, run_o});
    if (!st[1]) chk("range pin", {31'h0, st[0]}, {31'h0, slow});
  endtask

  // notes n pulse measurements of one channel, then waits for them to drain
  task automatic see(input int c, input int n, input int s, input int w, input int g);
    int t;
    t = 0;
    repeat (n) pq.push_back({12'(g), 10'(w), 10'(s)});
    @(posedge clk);
    wsel <= 5'(c);
    watch <= 1'b1;
    while (pq.size() > 0 && t < 4000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 4000) chk("pulse wait", 32'h1, 32'h0);
    pq.delete();
    watch <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1 && cyc && !we) begin
      if (eq.size() == 0) chk("read note", 32'h1, 32'h0);
      else chk(nq.pop_front(), eq.pop_front(), dat_o & mq.pop_front());
    end
    if (mv === 1'b1) begin
      if (pq.size() == 0) chk("pulse note", 32'h1, 32'h0);
      else chk("pulse timing", pq.pop_front(), meas);
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 80000);
    $display("watchdog expired");
    num_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(33));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, `REG_CTRL, 32'h0);
    bus(1'b0, `REG_CYCLE, 32'h0);
    bus(1'b0, `REG_STATUS, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    bus(1'b0, 8'h20, 32'h0, 32'hFFFF_FFFF, "unmapped");
    wr(`REG_CTRL, 32'h28);
    bus(1'b0, `REG_CTRL, 32'h28, 32'hFFFF_FFFF, "ctrl");
    repeat (3) begin
      k = $urandom % 17;
      v = $urandom & 32'h001F_FFFF;
      wr(`REG_PHASE_BASE + 8'(8 * k), v);
      bus(1'b0, `REG_PHASE_BASE + 8'(8 * k), v, 32'hFFFF_FFFF, "phase");
    end
    wr(`REG_CTRL, 32'h0);
    $display("test registers done");
    for (int c = 0; c < 17; c++) ph(c, 0, 0);
    for (int i = 0; i < 4; i++) ph(fk[i], fs[i], fw[i]);
    run(100, 8'h01, 8'h04);
    for (int i = 0; i < 4; i++) see(fk[i], 2, fs[i], fw[i], 96);
    wr(`REG_CTRL, 32'h06);
    ph(1, 150, 20);
    run(100, 8'h01, 8'h04);
    see(1, 2, 54, 20, 192);
    wr(`REG_CTRL, 32'h06);
    $display("test fast range done");
    run(100, 8'h09, 8'h04);
    see(0, 1, 0, 8, 96);
    acc = 14'h0;
    repeat (300) begin
      @(posedge clk);
      acc |= ph_o;
    end
    chk("seven unused", 32'h0, {18'h0, acc & 14'h3FF0});
    wr(`REG_CTRL, 32'h06);
    $display("test seven phase done");
    for (int c = 0; c < 4; c++) begin
      run(100, 8'(c * 16 + 1), ms[c]);
      if (ms[c][1]) begin
        wr(`REG_CTRL, 32'(c * 16 + 1));
        repeat (40) @(posedge clk);
        bus(1'b0, `REG_STATUS, {24'h0, ms[c]}, 32'hFE, "sticky");
        chk("halted outputs", 32'h0, {15'h0, ds, lo, hi, ph_o});
      end
      wr(`REG_CTRL, 32'h06);
    end
    bus(1'b0, `REG_STATUS, 32'h0, 32'h0E, "cleared");
    $display("test modes done");
    for (int c = 0; c < 17; c++) ph(c, 0, 0);
    for (int i = 0; i < 10; i++) begin
      ph(2, es[i], ew[i]);
      run(ec[i], 8'h01, est[i]);
      wr(`REG_CTRL, 32'h06);
    end
    $display("test range checks done");
    // slow settings kept off the cycle length itself
    ph(3, 50, 1000);
    run(20000, 8'h01, 8'h05);
    see(3, 2, 0, 2 * SDIV, 39 * SDIV);
    wr(`REG_CTRL, 32'h06);
    ph(3, 1000, 20000);
    run(50000, 8'h01, 8'h05);
    see(3, 2, 2 * SDIV, 39 * SDIV, 98 * SDIV);
    wr(`REG_CTRL, 32'h06);
    $display("test slow range done");
    end_sim();
  end
endmodule
